//--- complementary_pwm_output_stage_bench.sv
// Self-checking bench for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module complementary_pwm_output_stage_bench;
    import cpw_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, sync = 1'b0, clr = 1'b0, en = 1'b0;
    logic [5:0] adr = 6'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic wq, m1, c1, m2, f1, f2, upd, irq, shoot;
    logic [15:0] hc, lc, ac, r = 16'h002a, c;
    logic [31:0] exq[$];
    int err_total = 0, checked = 0, cyc = 0, n;
    localparam logic [2:0] MD [8] = '{3'h5, 3'h0, 3'h4, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    localparam logic [15:0] MX [8] = '{16'h28, 16'h28, 16'h0, 16'h28, 16'h0, 16'h14, 16'h0a, 16'h1e};
    localparam logic [15:0] PO [3] = '{16'h20, 16'h10, 16'h10};
    localparam logic [15:0] PI [3] = '{16'h0, 16'h4, 16'h0};
    localparam logic [15:0] PX [3] = '{16'h1e, 16'h28, 16'h0};
    localparam logic [15:0] EO [3] = '{16'h0, 16'h1, 16'h4};
    localparam logic [15:0] EM [3] = '{16'h0, 16'h14, 16'h0};
    localparam logic [15:0] EC [3] = '{16'h0, 16'h0, 16'h14};
    localparam logic [7:0] DG [7] = '{8'h05, 8'h81, 8'hc1, 8'he1, 8'h05, 8'h05, 8'h05};
    localparam logic [1:0] DK [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    localparam logic [15:0] DV [7] = '{16'h5, 16'h82, 16'h108, 16'h210, 16'h0a, 16'h14, 16'h5};
    always #10 clk = ~clk;
    cpw_timer #(.VARIANT(VAR_TWO_COMP)) cpw_timer_i (.sys_clk_i(clk), .rst_i(rst),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'h3), .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .sync_i(sync),
        .main_output1_o(m1), .comp_output1_o(c1), .main_output2_o(m2), .compare_flag1_o(f1),
        .compare_flag2_o(f2), .update_flag_o(upd), .irq_o(irq));
    cpw_gate_model cpw_gate_model_i (.clk_i(clk), .rst_i(rst), .clr_i(clr), .en_i(en),
        .hi_i(m1), .lo_i(c1), .aux_i(m2), .hi_cnt_o(hc), .lo_cnt_o(lc), .aux_cnt_o(ac),
        .shoot_o(shoot));
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    // Bus access; holds the request until waitrequest is seen low
    task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {16'h0, d};
        @(posedge clk);
        while (wq !== 1'b0) @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : acc
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        exq.push_back(e);
        acc(1'b0, a, 16'h0);
    endtask : rdc
    task automatic wu;
        @(posedge clk);
        while (upd !== 1'b1) @(posedge clk);
    endtask : wu
    // Two updates first so that shadowed settings have landed
    task automatic meas(input int w);
        wu();
        wu();
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        en <= 1'b1;
        repeat (w) @(posedge clk);
        en <= 1'b0;
        @(posedge clk);
    endtask : meas
    always @(posedge clk) begin
        if (rd && wq === 1'b0) chk(rdat, exq.pop_front());
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(ADDR_RELOAD, {16'h0, RELOAD_RST});
        rdc(ADDR_OSC, {16'h0, OSC_RST});
        rdc(ADDR_IDLE, {16'h0, IDLE_RST});
        rdc(6'h2c, 32'h0);
        acc(1'b1, ADDR_CTRL, 16'h0);
        acc(1'b1, ADDR_RELOAD, 16'h13);
        acc(1'b1, ADDR_CMP1, 16'h0a);
        acc(1'b1, ADDR_CMP2, 16'h5);
        acc(1'b1, ADDR_MODE, 16'h66);
        sync <= 1'b1;
        @(posedge clk);
        sync <= 1'b0;
        wu();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (upd !== 1'b1);
        chk(32'(n), 32'h14);
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, ADDR_MODE, {9'h0, MD[i], 4'h6});
            meas(40);
            chk({16'h0, ac}, {16'h0, MX[i]});
        end
        acc(1'b1, ADDR_MODE, 16'h66);
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, ADDR_OSC, PO[i]);
            acc(1'b1, ADDR_IDLE, PI[i]);
            meas(40);
            chk({16'h0, ac}, {16'h0, PX[i]});
        end
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, ADDR_OSC, EO[i]);
            meas(40);
            chk({16'h0, hc}, {16'h0, EM[i]});
            chk({16'h0, lc}, {16'h0, EC[i]});
        end
        acc(1'b1, ADDR_OSC, 16'h0);
        for (int i = 0; i < 3; i++) begin
            r = nxt(r);
            c = r % 16'h13 + 16'h1;
            acc(1'b1, ADDR_CMP2, c);
            meas(40);
            chk({16'h0, ac}, {15'h0, c, 1'b0});
        end
        acc(1'b1, ADDR_RELOAD, 16'h7cf);
        acc(1'b1, ADDR_CMP1, 16'h3e8);
        acc(1'b1, ADDR_CMP2, 16'h5dc);
        acc(1'b1, ADDR_OSC, 16'h5);
        for (int i = 0; i < 7; i++) begin
            acc(1'b1, ADDR_CTRL, {6'h0, DK[i], 8'h0});
            acc(1'b1, ADDR_DT, {8'h0, DG[i]});
            meas(2000);
            chk({16'h0, hc}, {16'h0, 16'h3e8 - DV[i]});
            chk({16'h0, lc}, {16'h0, 16'h3e8 - DV[i]});
        end
        chk({31'h0, shoot}, 32'h0);
        acc(1'b1, ADDR_MASK, 16'h0);
        wu();
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        acc(1'b1, ADDR_MASK, 16'h1);
        rdc(ADDR_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rdc(ADDR_STATUS, 32'h7);
        rdc(ADDR_STATUS, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wrap_up();
    end
endmodule : complementary_pwm_output_stage_bench
bind cpw_timer cpw_timer_props cpw_timer_props_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_readdata_o(avs_readdata_o), .sync_i(sync_i), .main_output1_o(main_output1_o),
    .comp_output1_o(comp_output1_o), .compare_flag1_o(compare_flag1_o),
    .compare_flag2_o(compare_flag2_o), .update_flag_o(update_flag_o), .irq_o(irq_o));
`default_nettype wire

//--- cpw_gate_model.sv
// Gate-driver pair model that watches the PWM pins
`timescale 1ns/1ps
`default_nettype none
module cpw_gate_model (
    // Clock and control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic en_i,
    // Gate inputs
    input wire logic hi_i,
    input wire logic lo_i,
    input wire logic aux_i,
    // Observations
    output logic [15:0] hi_cnt_o,
    output logic [15:0] lo_cnt_o,
    output logic [15:0] aux_cnt_o,
    output logic shoot_o
);
    // On-time of each gate inside the measuring window
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            hi_cnt_o <= 16'h0;
            lo_cnt_o <= 16'h0;
            aux_cnt_o <= 16'h0;
        end else if (en_i) begin
            hi_cnt_o <= hi_cnt_o + {15'h0, hi_i};
            lo_cnt_o <= lo_cnt_o + {15'h0, lo_i};
            aux_cnt_o <= aux_cnt_o + {15'h0, aux_i};
        end
    end
    // Both switches of a leg on shorts the supply, so it latches
    always_ff @(posedge clk_i) begin
        if (rst_i) shoot_o <= 1'b0;
        else if (hi_i && lo_i) shoot_o <= 1'b1;
    end
endmodule : cpw_gate_model
`default_nettype wire

//--- cpw_pkg.sv
// Package for the complementary PWM output stage
package cpw_pkg;
    // Register word offsets (byte addresses)
    localparam logic [5:0] ADDR_CTRL = 6'h00;
    localparam logic [5:0] ADDR_RELOAD = 6'h04;
    localparam logic [5:0] ADDR_CMP1 = 6'h08;
    localparam logic [5:0] ADDR_CMP2 = 6'h0c;
    localparam logic [5:0] ADDR_MODE = 6'h10;
    localparam logic [5:0] ADDR_OSC = 6'h14;
    localparam logic [5:0] ADDR_DT = 6'h18;
    localparam logic [5:0] ADDR_IDLE = 6'h1c;
    localparam logic [5:0] ADDR_STATUS = 6'h20;
    localparam logic [5:0] ADDR_MASK = 6'h24;
    localparam logic [5:0] ADDR_COUNT = 6'h28;
    // Control register fields
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_CMS_LO = 5;
    localparam int CTRL_CKD_LO = 8;
    // Output stage configuration bits
    localparam int OSC_C1E = 0;
    localparam int OSC_C1P = 1;
    localparam int OSC_C1NE = 2;
    localparam int OSC_C1NP = 3;
    localparam int OSC_C2E = 4;
    localparam int OSC_C2P = 5;
    localparam int OSC_C2NP = 7;
    // Idle level bits
    localparam int IDLE_OUT1 = 0;
    localparam int IDLE_COMP1 = 1;
    localparam int IDLE_OUT2 = 2;
    // Status bits
    localparam int ST_UPD = 0;
    localparam int ST_CMP1 = 1;
    localparam int ST_CMP2 = 2;
    // Reset values
    localparam logic [15:0] RELOAD_RST = 16'hffff;
    localparam logic [15:0] OSC_RST = 16'h0000;
    localparam logic [15:0] IDLE_RST = 16'h0000;
    // Reference modes
    typedef enum logic [2:0] {
        RM_FROZEN = 3'h0,
        RM_SET = 3'h1,
        RM_CLEAR = 3'h2,
        RM_TOGGLE = 3'h3,
        RM_LOW = 3'h4,
        RM_HIGH = 3'h5,
        RM_PWM1 = 3'h6,
        RM_PWM2 = 3'h7
    } cpw_ref_mode_type;
    // Dead-time engine state, one-hot
    typedef enum logic [2:0] {
        DT_IDLE = 3'b001,
        DT_WAIT = 3'b010,
        DT_ON = 3'b100
    } cpw_dt_state_type;
    // Configuration sampled at update events
    typedef struct packed {
        logic [15:0] reload;
        logic [15:0] cmp1;
        logic [15:0] cmp2;
        logic [2:0] mode1;
        logic [2:0] mode2;
        logic [7:0] dtg;
        logic [1:0] deadtime_clock_divide;
    } cpw_shadow_type;
    // Variant selectors
    localparam int VAR_TWO_COMP = 0;
    localparam int VAR_ONE_COMP = 1;
    localparam int VAR_TWO_PLAIN = 2;
    localparam int VAR_ONE_PLAIN = 3;
endpackage : cpw_pkg

//--- cpw_timer.sv
// Reduced timer with complementary PWM output stage and Avalon-MM slave
// How it works
// - Sixteen-bit counter, edge-aligned, counting upward only.
// - Polarity bit 0 keeps output active high, 1 inverts it.
// - Channel 2 enable 0 follows reference; 1 disables output to its idle level.
// - Channel 1 enables: none inactive, main, comp, or both with dead time.
// - Two-channel complementary variant: channel 2 single output, polarity and enable.
// - Complementary mode delays each rising edge of both outputs by dead time.
// - Dead time from 8-bit code using four formulas by top bits.
// - Dead-time tick is 1, 2 or 4 counter clocks; code 11 unsupported.
// - Two-channel complementary drives two mains, one comp, two compare flags, update.
// - One-channel complementary drives main, comp, one compare flag, update flag.
// - Two-channel plain variant ignores comp polarity, has no dead time.
// - One-channel plain variant ignores comp polarity, drives one main only.
// - Disabled channel 2 output, or both channel 1 outputs when neither is enabled, take per-output idle bit: 0 low, 1 high.
// - Sync rising edge resets counter and loads dynamic configuration.
// - Reference mode selects one of eight behaviours.
// - Compare and update flags are single-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module cpw_timer
    import cpw_pkg::*;
#(
    parameter int VARIANT = VAR_TWO_COMP,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Sync input
    input wire logic sync_i,
    // PWM outputs
    output logic main_output1_o,
    output logic comp_output1_o,
    output logic main_output2_o,
    // Event pulses and interrupt
    output logic compare_flag1_o,
    output logic compare_flag2_o,
    output logic update_flag_o,
    output logic irq_o
);
    localparam bit HAS_COMP = (VARIANT == VAR_TWO_COMP) || (VARIANT == VAR_ONE_COMP);
    localparam bit HAS_CH2 = (VARIANT == VAR_TWO_COMP) || (VARIANT == VAR_TWO_PLAIN);

    // Software-visible registers, then shadow, counter and internal state
    logic [15:0] counter_control_reg;
    logic [15:0] reload_value;
    logic [15:0] compare_value1;
    logic [15:0] compare_value2;
    logic [15:0] reference_mode_field;
    logic [15:0] output_stage_config;
    logic [15:0] deadtime_break_reg;
    logic [15:0] idle_level_select;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    cpw_shadow_type shadow;
    logic [CNT_W-1:0] count;
    logic sync_q;
    logic ack;
    logic ref1;
    logic ref2;
    logic upd_evt;
    logic match1;
    logic match2;
    logic sync_rise;

    // Byte-lane merge for a write
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = old;
        if (be[0]) merge16[7:0] = wd[7:0];
        if (be[1]) merge16[15:8] = wd[15:8];
    endfunction : merge16

    // Polarity, enable and idle level of one output
    function automatic logic drive_pin(input logic val, input logic pol, input logic dis,
                                       input logic idle);
        drive_pin = dis ? idle : (val ^ pol);
    endfunction : drive_pin

    // Next reference level for one channel
    function automatic logic next_ref(input logic cur, input logic [2:0] mode,
                                      input logic match, input logic below);
        case (cpw_ref_mode_type'(mode))
            RM_FROZEN: next_ref = cur;
            RM_SET: next_ref = match ? 1'b1 : cur;
            RM_CLEAR: next_ref = match ? 1'b0 : cur;
            RM_TOGGLE: next_ref = match ? ~cur : cur;
            RM_LOW: next_ref = 1'b0;
            RM_HIGH: next_ref = 1'b1;
            RM_PWM1: next_ref = below;
            RM_PWM2: next_ref = ~below;
            default: next_ref = cur;
        endcase
    endfunction : next_ref

    // Register writes hold one wait cycle, read data registered
    wire logic bus_req = (avs_read_i || avs_write_i) && !ack;
    // Write lands on the answer edge, when waitrequest is seen low
    wire logic wr_go = avs_write_i && ack;
    wire logic rd_status = avs_read_i && ack && (avs_address_i == ADDR_STATUS);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !bus_req;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            counter_control_reg <= 16'h0000;
            reload_value <= RELOAD_RST;
            compare_value1 <= 16'h0000;
            compare_value2 <= 16'h0000;
            reference_mode_field <= 16'h0000;
            output_stage_config <= OSC_RST;
            deadtime_break_reg <= 16'h0000;
            idle_level_select <= IDLE_RST;
            irq_mask <= 3'h0;
        end else if (wr_go) begin
            case (avs_address_i)
                // Alignment and direction bits stay at 0 (only edge-aligned up)
                ADDR_CTRL: counter_control_reg <= merge16(counter_control_reg, avs_writedata_i,
                                                          avs_byteenable_i) & 16'h0300;
                ADDR_RELOAD: reload_value <= merge16(reload_value, avs_writedata_i,
                                                     avs_byteenable_i);
                ADDR_CMP1: compare_value1 <= merge16(compare_value1, avs_writedata_i,
                                                     avs_byteenable_i);
                ADDR_CMP2: compare_value2 <= merge16(compare_value2, avs_writedata_i,
                                                     avs_byteenable_i);
                ADDR_MODE: reference_mode_field <= merge16(reference_mode_field,
                                                           avs_writedata_i,
                                                           avs_byteenable_i) & 16'h0077;
                ADDR_OSC: output_stage_config <= merge16(output_stage_config, avs_writedata_i,
                                                         avs_byteenable_i) & 16'h00bf;
                ADDR_DT: deadtime_break_reg <= merge16(deadtime_break_reg, avs_writedata_i,
                                                       avs_byteenable_i) & 16'h00ff;
                ADDR_IDLE: idle_level_select <= merge16(idle_level_select, avs_writedata_i,
                                                        avs_byteenable_i) & 16'h0007;
                ADDR_MASK: if (avs_byteenable_i[0]) irq_mask <= avs_writedata_i[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack) begin
            case (avs_address_i)
                ADDR_CTRL: avs_readdata_o <= {16'h0000, counter_control_reg};
                ADDR_RELOAD: avs_readdata_o <= {16'h0000, reload_value};
                ADDR_CMP1: avs_readdata_o <= {16'h0000, compare_value1};
                ADDR_CMP2: avs_readdata_o <= {16'h0000, compare_value2};
                ADDR_MODE: avs_readdata_o <= {16'h0000, reference_mode_field};
                ADDR_OSC: avs_readdata_o <= {16'h0000, output_stage_config};
                ADDR_DT: avs_readdata_o <= {16'h0000, deadtime_break_reg};
                ADDR_IDLE: avs_readdata_o <= {16'h0000, idle_level_select};
                ADDR_STATUS: avs_readdata_o <= {29'h0000_0000, irq_status};
                ADDR_MASK: avs_readdata_o <= {29'h0000_0000, irq_mask};
                ADDR_COUNT: avs_readdata_o <= {{(32 - CNT_W){1'b0}}, count};
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Counter and update event
    assign sync_rise = sync_i && !sync_q;
    assign upd_evt = (count == shadow.reload[CNT_W-1:0]) || sync_rise;
    assign match1 = (count == shadow.cmp1[CNT_W-1:0]);
    assign match2 = HAS_CH2 && (count == shadow.cmp2[CNT_W-1:0]);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= sync_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (upd_evt) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    // Shadow copy loaded only at update events
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            shadow <= '0;
            shadow.reload <= RELOAD_RST;
        end else if (upd_evt) begin
            shadow.reload <= reload_value;
            shadow.cmp1 <= compare_value1;
            shadow.cmp2 <= compare_value2;
            shadow.mode1 <= reference_mode_field[2:0];
            shadow.mode2 <= reference_mode_field[6:4];
            shadow.dtg <= HAS_COMP ? deadtime_break_reg[7:0] : 8'h00;
            shadow.deadtime_clock_divide <= HAS_COMP ? counter_control_reg[CTRL_CKD_LO +: 2] : 2'h0;
        end
    end

    // Reference signals
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ref1 <= 1'b0;
            ref2 <= 1'b0;
        end else begin
            ref1 <= next_ref(ref1, shadow.mode1, match1, count < shadow.cmp1);
            ref2 <= HAS_CH2 ? next_ref(ref2, shadow.mode2, match2, count < shadow.cmp2) : 1'b0;
        end
    end

    // Event pulses
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            compare_flag1_o <= 1'b0;
            compare_flag2_o <= 1'b0;
            update_flag_o <= 1'b0;
        end else begin
            compare_flag1_o <= match1;
            compare_flag2_o <= match2;
            update_flag_o <= upd_evt;
        end
    end

    // Sticky status, cleared by a read; a new event wins over the clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_status <= 3'h0;
        end else begin
            // Clear only the bits the read returned, so a later event is not lost
            irq_status <= (rd_status ? irq_status & ~avs_readdata_o[2:0] : irq_status)
                          | {match2, match1, upd_evt};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // Dead-time tick divider and length
    logic [1:0] tick_div;
    logic tick;
    logic [11:0] dt_len;
    logic [11:0] dt_cnt;
    logic dt_main;
    logic dt_comp;
    logic ref1_d;
    cpw_dt_state_type dt_state;

    always_comb begin
        case (shadow.deadtime_clock_divide)
            2'h0: tick = 1'b1;
            2'h1: tick = tick_div[0];
            2'h2: tick = &tick_div;
            default: tick = 1'b1;
        endcase
    end

    always_comb begin
        casez (shadow.dtg[7:5])
            3'b0??: dt_len = {4'h0, shadow.dtg};
            3'b10?: dt_len = {5'h00, 7'h40 + {1'b0, shadow.dtg[5:0]}} << 1;
            3'b110: dt_len = {6'h00, 6'h20 + {1'b0, shadow.dtg[4:0]}} << 3;
            default: dt_len = {6'h00, 6'h20 + {1'b0, shadow.dtg[4:0]}} << 4;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tick_div <= 2'h0;
        end else if (ref1 != ref1_d) begin
            // Restart with each dead-time count, so the delay is whole ticks
            tick_div <= 2'h0;
        end else begin
            tick_div <= tick_div + 2'h1;
        end
    end

    // Delays the rising side of whichever output turns on
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ref1_d <= 1'b0;
            dt_state <= DT_IDLE;
            dt_cnt <= 12'h000;
            dt_main <= 1'b0;
            dt_comp <= 1'b0;
        end else begin
            ref1_d <= ref1;
            case (dt_state)
                DT_IDLE, DT_ON: begin
                    if (ref1 != ref1_d) begin
                        dt_main <= 1'b0;
                        dt_comp <= 1'b0;
                        dt_cnt <= dt_len;
                        dt_state <= (dt_len == 12'h000) ? DT_ON : DT_WAIT;
                        if (dt_len == 12'h000) begin
                            dt_main <= ref1;
                            dt_comp <= ~ref1;
                        end
                    end else if (dt_state == DT_IDLE) begin
                        dt_main <= ref1;
                        dt_comp <= ~ref1;
                        dt_state <= DT_ON;
                    end
                end
                DT_WAIT: begin
                    if (ref1 != ref1_d) begin
                        dt_cnt <= dt_len;
                    end else if (tick) begin
                        if (dt_cnt <= 12'h001) begin
                            dt_main <= ref1;
                            dt_comp <= ~ref1;
                            dt_state <= DT_ON;
                        end else begin
                            dt_cnt <= dt_cnt - 12'h001;
                        end
                    end
                end
                default: dt_state <= DT_IDLE;
            endcase
        end
    end

    // Output stage acts on the live configuration, not the shadow
    logic c1e;
    logic c1ne;
    logic [1:0] ch1_pair;
    assign c1e = output_stage_config[OSC_C1E];
    assign c1ne = HAS_COMP && output_stage_config[OSC_C1NE];

    always_comb begin
        case ({c1ne, c1e})
            2'b00: ch1_pair = 2'b00;
            2'b01: ch1_pair = {ref1, 1'b0};
            2'b10: ch1_pair = {1'b0, ref1};
            default: ch1_pair = {dt_main, dt_comp};
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            main_output1_o <= 1'b0;
            comp_output1_o <= 1'b0;
            main_output2_o <= 1'b0;
        end else begin
            main_output1_o <= drive_pin(ch1_pair[1], output_stage_config[OSC_C1P],
                                        !c1e && !c1ne, idle_level_select[IDLE_OUT1]);
            comp_output1_o <= HAS_COMP ? drive_pin(ch1_pair[0],
                                                   output_stage_config[OSC_C1NP],
                                                   !c1e && !c1ne,
                                                   idle_level_select[IDLE_COMP1]) : 1'b0;
            main_output2_o <= HAS_CH2 ? drive_pin(ref2, output_stage_config[OSC_C2P],
                                                  output_stage_config[OSC_C2E],
                                                  idle_level_select[IDLE_OUT2]) : 1'b0;
        end
    end
endmodule : cpw_timer
`default_nettype wire

//--- cpw_timer_props.sv
// Port-level checks for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module cpw_timer_props (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic [31:0] avs_readdata_o,
    // Timer pins
    input wire logic sync_i,
    input wire logic main_output1_o,
    input wire logic comp_output1_o,
    input wire logic compare_flag1_o,
    input wire logic compare_flag2_o,
    input wire logic update_flag_o,
    input wire logic irq_o
);
    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic [1:0] cmp_seen;
    logic [3:0] since_req;
    assign req = avs_read_i || avs_write_i;
    // Sync restarts the count, so it also opens a new period
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || update_flag_o || sync_i) cmp_seen <= 2'h0;
        else if (compare_flag1_o && cmp_seen != 2'h3) cmp_seen <= cmp_seen + 2'h1;
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || req) since_req <= 4'h0;
        else if (since_req != 4'hf) since_req <= since_req + 4'h1;
    end
    req_answer_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus request not answered after one cycle");
    idle_wait_a: assert property (!req |=> avs_waitrequest_o)
        else $error("waitrequest low without a request");
    read_hold_a: assert property (!$stable(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o)
        else $error("read data changed outside a read answer");
    upd_pulse_a: assert property (update_flag_o |=> !update_flag_o)
        else $error("update flag longer than one cycle");
    cmp_pulse_a: assert property (compare_flag1_o |=> !compare_flag1_o)
        else $error("compare flag 1 longer than one cycle");
    cmp2_pulse_a: assert property ($rose(compare_flag2_o) |=> $fell(compare_flag2_o))
        else $error("compare flag 2 longer than one cycle");
    one_cmp_a: assert property (compare_flag1_o |-> cmp_seen == 2'h0)
        else $error("two compare pulses in one period");
    no_overlap_a: assert property (!(main_output1_o && comp_output1_o))
        else $error("main and complementary outputs active together");
    irq_fall_a: assert property ($fell(irq_o) |-> since_req < 4'h4)
        else $error("interrupt dropped without a bus access");
    cover property (update_flag_o && irq_o);
    cover property (compare_flag1_o ##[1:600] compare_flag2_o);
    cover property ($fell(irq_o));
endmodule : cpw_timer_props
`default_nettype wire
